// file: include/gtu_pkg.sv
// package: constants, register map and types of the general timer unit
package gtu_pkg;

	// ==========================================================
	// register map (word index on the plain register port)
	localparam int          GTU_AW         = 4;
	localparam int          GTU_DW         = 16;
	localparam logic [3:0]  GTU_REG_CTL0   = 4'h0; // core ctl
	localparam logic [3:0]  GTU_REG_VAL0   = 4'h5; // core value
	localparam logic [3:0]  GTU_REG_CAPTURE_RELOAD_REG = 4'ha; // capture_reload_reg
	localparam logic [3:0]  GTU_REG_STAT   = 4'hb; // latches and pins

	// timer slots: ctl at CTL0+slot, value at VAL0+slot
	localparam int          GTU_NT         = 5;
	localparam int          GTU_CORE       = 0; // core_timer
	localparam int          GTU_AUXL       = 1; // aux_timer_low
	localparam int          GTU_AUXH       = 2; // aux_timer_high
	localparam int          GTU_SAUX       = 3; // second_aux_timer
	localparam int          GTU_SCORE      = 4; // second_core_timer

	// ==========================================================
	// core_timer_group control fields
	localparam int          GTU_F_MODE     = 0;  // 2 bits
	localparam int          GTU_F_RUN      = 2;
	localparam int          GTU_F_DOWN     = 3;
	localparam int          GTU_F_DIRPIN   = 4;
	localparam int          GTU_F_PRE      = 5;  // 3 bits
	localparam int          GTU_F_LCLK     = 8;  // aux: clock from latch
	localparam int          GTU_F_ROLE     = 9;  // aux: 2 bits
	localparam int          GTU_F_EDGE     = 11; // 2 bits rise/fall
	localparam int          GTU_F_RLSEL    = 13; // aux: 2 bits
	localparam int          GTU_F_LVL      = 15; // gate level/core out

	// fast_timer_group control fields
	localparam int          GTU_G_EXT      = 0;
	localparam int          GTU_G_RUN      = 1;
	localparam int          GTU_G_DOWN     = 2;
	localparam int          GTU_G_DIRPIN   = 3;
	localparam int          GTU_G_PRE      = 4;  // 3 bits
	localparam int          GTU_G_LCLK     = 7;  // saux: fast latch clock
	localparam int          GTU_G_OUTEN    = 8;  // score: output enable
	localparam int          GTU_G_RLD      = 9;  // score: reload on wrap
	localparam int          GTU_G_CEDGE    = 10; // saux: 2 bits
	localparam int          GTU_G_CLR      = 12; // saux: clear on capture
	localparam int          GTU_G_CSRC     = 13; // saux: 2 bits

	// ==========================================================
	// timing: base step of each group, in system clocks
	localparam logic [11:0] GTU_G1_BASE    = 12'h004;
	localparam logic [11:0] GTU_G2_BASE    = 12'h002;
	localparam logic [15:0] GTU_CTL_RST    = 16'h0000;

	// ==========================================================
	// enumerations
	typedef enum logic [1:0] {
		GTU_M_TIMER = 2'h0,
		GTU_M_GATED = 2'h1,
		GTU_M_COUNT = 2'h2,
		GTU_M_ENC   = 2'h3
	} gtu_mode_t;

	typedef enum logic [1:0] {
		GTU_R_COUNT = 2'h0,
		GTU_R_CAPT  = 2'h1,
		GTU_R_RELD  = 2'h2,
		GTU_R_OFF   = 2'h3
	} gtu_role_t;

	// ==========================================================
	// external pins, all asynchronous to the system clock
	typedef struct packed {
		logic core_in;   // core_count_input
		logic core_dir;  // core_direction_input
		logic auxl_in;
		logic auxl_dir;
		logic auxh_in;
		logic auxh_dir;
		logic saux_in;
		logic saux_dir;
		logic score_in;
		logic score_dir;
		logic cap_in;    // capture_input_pin
	} gtu_pins_t;

	// whole state of the unit
	typedef struct packed {
		logic [GTU_NT-1:0][15:0] cnt;
		logic [GTU_NT-1:0][15:0] ctl;
		logic [15:0]             capture_reload_reg;
		logic                    core_tl;
		logic                    core_tl_p;
		logic                    fast_tl;
		logic                    fast_tl_p;
		logic                    core_out;
		logic                    fast_out;
		logic                    cmp_tick;
		logic [11:0]             div;
		logic [15:0]             rdata;
		gtu_pins_t               s1;
		gtu_pins_t               s2;
		gtu_pins_t               s3;
	} gtu_state_t;

	localparam gtu_state_t  GTU_STATE_RST  = '0;

endpackage

// file: verilog/gtu_general_timer_unit.sv
// general_timer_unit: two timer groups behind a plain register port
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps

module gtu_general_timer_unit (
	// clock and reset
	input  wire logic                   mclk_i,
	input  wire logic                   srst_i,
	// register port
	input  wire logic [3:0]             addr_i,
	input  wire logic [15:0]            wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic      [15:0]            rdata_o,
	// external pins
	input  wire gtu_pkg::gtu_pins_t     pins_i,
	// outputs
	output logic                        core_toggle_o,
	output logic                        fast_toggle_o,
	output logic                        cmp_tick_o
);

	// ==========================================================
	// helpers

	// one count step; wrap reported both ways
	// the wrap flag comes from the old value, so a reload or a
	// latch flip decided in the same cycle still sees the event
	function automatic logic [16:0] step(input logic [15:0] v,
			input logic dn);
		logic wrap;
		logic [15:0] nv;
		wrap = dn ? (v == 16'h0000) : (v == 16'hffff);
		nv = dn ? (v - 16'h0001) : (v + 16'h0001);
		return {wrap, nv};
	endfunction

	// edge match: sel[0] rising, sel[1] falling
	// both bits set give either edge; zero never matches, which
	// is how an unused trigger is switched off
	function automatic logic hit(input logic now, input logic old,
			input logic [1:0] sel);
		return (sel[0] & now & ~old) | (sel[1] & ~now & old);
	endfunction

	// prescaler tap: base times two to the pre
	// all low bits of the free divider set: one cycle in each
	// period, so every timer of a group steps on the same phase
	// and the finest step is the group's base
	function automatic logic tap(input logic [11:0] dv,
			input logic [11:0] base, input logic [2:0] pre);
		logic [11:0] m;
		m = (base << pre) - 12'h001;
		return (dv & m) == m;
	endfunction

	// ==========================================================
	// state
	// every counter, control word, latch and pin stage sits in one
	// packed struct; the comb process fills st_d, one flop set holds it
	gtu_pkg::gtu_state_t st_q;  // registered state
	gtu_pkg::gtu_state_t st_d;  // next state

	logic [2:0][0:0]     pin_n; // synced timer input, now
	logic [2:0][0:0]     pin_o; // synced timer input, previous
	logic [2:0][0:0]     dir_n; // synced direction, now
	logic [2:0][0:0]     dir_o; // synced direction, previous

	// ==========================================================
	// pin views of the first group, from synced stages only
	// index 0 is the core timer, 1 and 2 the aux timers; now is
	// the second stage, previous the third, so an edge shows for
	// exactly one cycle
	always_comb begin
		pin_n[0] = st_q.s2.core_in;
		pin_o[0] = st_q.s3.core_in;
		dir_n[0] = st_q.s2.core_dir;
		dir_o[0] = st_q.s3.core_dir;
		pin_n[1] = st_q.s2.auxl_in;
		pin_o[1] = st_q.s3.auxl_in;
		dir_n[1] = st_q.s2.auxl_dir;
		dir_o[1] = st_q.s3.auxl_dir;
		pin_n[2] = st_q.s2.auxh_in;
		pin_o[2] = st_q.s3.auxh_in;
		dir_n[2] = st_q.s2.auxh_dir;
		dir_o[2] = st_q.s3.auxh_dir;
	end

	// ==========================================================
	// next-state logic
	always_comb begin
		logic [15:0]         c;     // control word of a timer
		gtu_pkg::gtu_mode_t  md;    // mode of a timer
		gtu_pkg::gtu_role_t  rl;    // role of an aux timer
		logic                ev;    // count event
		logic                dn;    // count down
		logic [16:0]         r;     // step result
		logic                trg;   // reload trigger
		logic                crise; // core latch rose
		logic                cfall; // core latch fell
		logic                ftog;  // fast latch toggled
		logic                cap;   // second group capture
		logic [15:0]         rv;    // read value

		c = '0;
		md = gtu_pkg::GTU_M_TIMER;
		rl = gtu_pkg::GTU_R_COUNT;
		ev = 1'b0;
		dn = 1'b0;
		r = '0;
		trg = 1'b0;
		cap = 1'b0;
		rv = '0;
		crise = 1'b0;
		cfall = 1'b0;
		ftog = 1'b0;
		st_d = st_q;

		// synchronisers: first stage feeds only the second
		// a pin may change next to the clock edge; stage one may then
		// settle late, so no logic but stage two ever looks at it
		st_d.s1 = pins_i;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		st_d.div = st_q.div + 12'h001;
		st_d.core_tl_p = st_q.core_tl;
		st_d.fast_tl_p = st_q.fast_tl;
		st_d.cmp_tick = 1'b0;
		crise = st_q.core_tl & ~st_q.core_tl_p;
		cfall = ~st_q.core_tl & st_q.core_tl_p;
		ftog = st_q.fast_tl ^ st_q.fast_tl_p;

		// ------------------------------------------------------
		// first group: counting of core and aux timers
		// the aux timers share this loop; a capture or reload role
		// freezes the count, the role loop below then owns the value
		for (int i = 0; i < 3; i++) begin
			c = st_q.ctl[i];
			md = gtu_pkg::gtu_mode_t'(c[gtu_pkg::GTU_F_MODE +: 2]);
			rl = (i == gtu_pkg::GTU_CORE) ? gtu_pkg::GTU_R_COUNT :
				gtu_pkg::gtu_role_t'(c[gtu_pkg::GTU_F_ROLE +: 2]);
			case (md)
				// prescaled clock, at least 4 clocks a step
				gtu_pkg::GTU_M_TIMER: begin
					ev = tap(st_q.div, gtu_pkg::GTU_G1_BASE,
						c[gtu_pkg::GTU_F_PRE +: 3]);
				end
				// prescaled clock while gate at its level
				gtu_pkg::GTU_M_GATED: begin
					ev = tap(st_q.div, gtu_pkg::GTU_G1_BASE,
						c[gtu_pkg::GTU_F_PRE +: 3]) &
						(pin_n[i] == c[gtu_pkg::GTU_F_LVL]);
				end
				// pin edges, or core latch edges for aux
				gtu_pkg::GTU_M_COUNT: begin
					if (i != gtu_pkg::GTU_CORE &&
							c[gtu_pkg::GTU_F_LCLK]) begin
						ev = hit(st_q.core_tl, st_q.core_tl_p,
							c[gtu_pkg::GTU_F_EDGE +: 2]);
					end else begin
						ev = hit(pin_n[i], pin_o[i],
							c[gtu_pkg::GTU_F_EDGE +: 2]);
					end
				end
				// any edge of A or B
				// one count per edge gives four counts per
				// sensor line period
				gtu_pkg::GTU_M_ENC: begin
					ev = (pin_n[i] != pin_o[i]) |
						(dir_n[i] != dir_o[i]);
				end
				default: begin
					ev = 1'b0;
				end
			endcase
			if (md == gtu_pkg::GTU_M_ENC) begin
				// A now against B before: up when they differ
				dn = ~(pin_n[i] ^ dir_o[i]);
			end else begin
				dn = c[gtu_pkg::GTU_F_DOWN] ^
					(c[gtu_pkg::GTU_F_DIRPIN] & dir_n[i]);
			end
			// capture and reload roles hold the count
			if (c[gtu_pkg::GTU_F_RUN] && ev &&
					rl == gtu_pkg::GTU_R_COUNT) begin
				r = step(st_q.cnt[i], dn);
				st_d.cnt[i] = r[15:0];
				if (i == gtu_pkg::GTU_CORE && r[16]) begin
					st_d.core_tl = ~st_q.core_tl;
				end
			end
		end

		// ------------------------------------------------------
		// first group: capture and reload roles of aux timers
		// the high aux timer runs second, so if both reload the core
		// in one cycle its value is the one that lands
		for (int i = 1; i < 3; i++) begin
			c = st_q.ctl[i];
			rl = gtu_pkg::gtu_role_t'(c[gtu_pkg::GTU_F_ROLE +: 2]);
			case (rl)
				// latch core value on the chosen pin edge
				gtu_pkg::GTU_R_CAPT: begin
					if (hit(pin_n[i], pin_o[i],
							c[gtu_pkg::GTU_F_EDGE +: 2])) begin
						st_d.cnt[i] = st_q.cnt[gtu_pkg::GTU_CORE];
					end
				end
				// load core from pin edge or latch transition
				gtu_pkg::GTU_R_RELD: begin
					case (c[gtu_pkg::GTU_F_RLSEL +: 2])
						2'h1: trg = crise;
						2'h2: trg = cfall;
						2'h3: trg = crise | cfall;
						default: trg = hit(pin_n[i], pin_o[i],
							c[gtu_pkg::GTU_F_EDGE +: 2]);
					endcase
					// low one on one edge, high one on the
					// other: the core then runs a PWM alone
					if (trg) begin
						st_d.cnt[gtu_pkg::GTU_CORE] =
							st_q.cnt[i];
					end
				end
				default: begin
					trg = 1'b0;
				end
			endcase
		end
		// latch onto the pin only when enabled
		st_d.core_out = st_d.core_tl &
			st_q.ctl[gtu_pkg::GTU_CORE][gtu_pkg::GTU_F_LVL];

		// ------------------------------------------------------
		// second group: second core timer
		// a wrap flips the fast latch and ticks the compare array for
		// one cycle; with reload on, the capture register refills it
		c = st_q.ctl[gtu_pkg::GTU_SCORE];
		ev = c[gtu_pkg::GTU_G_EXT] ?
			(st_q.s2.score_in & ~st_q.s3.score_in) :
			tap(st_q.div, gtu_pkg::GTU_G2_BASE,
				c[gtu_pkg::GTU_G_PRE +: 3]);
		dn = c[gtu_pkg::GTU_G_DOWN] ^
			(c[gtu_pkg::GTU_G_DIRPIN] & st_q.s2.score_dir);
		if (c[gtu_pkg::GTU_G_RUN] && ev) begin
			r = step(st_q.cnt[gtu_pkg::GTU_SCORE], dn);
			st_d.cnt[gtu_pkg::GTU_SCORE] = r[15:0];
			if (r[16]) begin
				st_d.fast_tl = ~st_q.fast_tl;
				st_d.cmp_tick = 1'b1;
				if (c[gtu_pkg::GTU_G_RLD]) begin
					st_d.cnt[gtu_pkg::GTU_SCORE] =
						st_q.capture_reload_reg;
				end
			end
		end
		st_d.fast_out = st_d.fast_tl & c[gtu_pkg::GTU_G_OUTEN];

		// ------------------------------------------------------
		// second group: second aux timer
		// clocked by the fast latch, its own pin or the prescaler,
		// in that order of precedence
		c = st_q.ctl[gtu_pkg::GTU_SAUX];
		if (c[gtu_pkg::GTU_G_LCLK]) begin
			ev = ftog;
		end else if (c[gtu_pkg::GTU_G_EXT]) begin
			ev = st_q.s2.saux_in & ~st_q.s3.saux_in;
		end else begin
			ev = tap(st_q.div, gtu_pkg::GTU_G2_BASE,
				c[gtu_pkg::GTU_G_PRE +: 3]);
		end
		dn = c[gtu_pkg::GTU_G_DOWN] ^
			(c[gtu_pkg::GTU_G_DIRPIN] & st_q.s2.saux_dir);
		if (c[gtu_pkg::GTU_G_RUN] && ev) begin
			r = step(st_q.cnt[gtu_pkg::GTU_SAUX], dn);
			st_d.cnt[gtu_pkg::GTU_SAUX] = r[15:0];
		end
		// capture source: pin, core count or direction input
		// the core pins are read from the same synchroniser as the
		// core timer, so both see one edge on the same cycle
		case (c[gtu_pkg::GTU_G_CSRC +: 2])
			2'h1: cap = hit(st_q.s2.core_in, st_q.s3.core_in,
				c[gtu_pkg::GTU_G_CEDGE +: 2]);
			2'h2: cap = hit(st_q.s2.core_dir, st_q.s3.core_dir,
				c[gtu_pkg::GTU_G_CEDGE +: 2]);
			2'h3: cap = hit(st_q.s2.core_in, st_q.s3.core_in,
				c[gtu_pkg::GTU_G_CEDGE +: 2]) |
				hit(st_q.s2.core_dir, st_q.s3.core_dir,
				c[gtu_pkg::GTU_G_CEDGE +: 2]);
			default: cap = hit(st_q.s2.cap_in, st_q.s3.cap_in,
				c[gtu_pkg::GTU_G_CEDGE +: 2]);
		endcase
		if (cap) begin
			st_d.capture_reload_reg = st_q.cnt[gtu_pkg::GTU_SAUX];
			if (c[gtu_pkg::GTU_G_CLR]) begin
				st_d.cnt[gtu_pkg::GTU_SAUX] = '0;
			end
		end

		// ------------------------------------------------------
		// register writes win over all hardware updates
		// map: 0..4 controls, 5..9 values, 0xa capture register;
		// the status word and 0xc..0xf ignore writes
		if (wr_i) begin
			if (addr_i < gtu_pkg::GTU_REG_VAL0) begin
				st_d.ctl[3'(addr_i - gtu_pkg::GTU_REG_CTL0)] = wdata_i;
			end else if (addr_i < gtu_pkg::GTU_REG_CAPTURE_RELOAD_REG) begin
				st_d.cnt[3'(addr_i - gtu_pkg::GTU_REG_VAL0)] = wdata_i;
			end else if (addr_i == gtu_pkg::GTU_REG_CAPTURE_RELOAD_REG) begin
				st_d.capture_reload_reg = wdata_i;
			end
		end

		// ------------------------------------------------------
		// read data one cycle after the strobe, zero otherwise
		// zero outside a read keeps rdata_o quiet for a bus that ORs
		// several slaves together
		if (addr_i < gtu_pkg::GTU_REG_VAL0) begin
			rv = st_q.ctl[3'(addr_i - gtu_pkg::GTU_REG_CTL0)];
		end else if (addr_i < gtu_pkg::GTU_REG_CAPTURE_RELOAD_REG) begin
			rv = st_q.cnt[3'(addr_i - gtu_pkg::GTU_REG_VAL0)];
		end else if (addr_i == gtu_pkg::GTU_REG_CAPTURE_RELOAD_REG) begin
			rv = st_q.capture_reload_reg;
		end else if (addr_i == gtu_pkg::GTU_REG_STAT) begin
			rv = {3'h0, st_q.fast_tl, st_q.core_tl, 11'(st_q.s2)};
		end else begin
			rv = '0;
		end
		st_d.rdata = rd_i ? rv : 16'h0000;
	end

	// ==========================================================
	// state register, synchronous reset
	// reset clears the divider as well, so prescaler phases restart
	// from the same point after every reset
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st_q <= gtu_pkg::GTU_STATE_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// outputs straight from flip-flops
	// the toggle outputs are already gated by their enables in the
	// next-state logic, so the pins never glitch
	assign rdata_o       = st_q.rdata;
	assign core_toggle_o = st_q.core_out;
	assign fast_toggle_o = st_q.fast_out;
	assign cmp_tick_o    = st_q.cmp_tick;

endmodule

// file: verif/gtu_chk.sv
// checker: port-level timing rules of the general timer unit
`timescale 1ns/1ps

module gtu_chk (
	// clock and reset
	input wire logic               mclk_i,
	input wire logic               srst_i,
	// register port
	input wire logic [3:0]         addr_i,
	input wire logic [15:0]        wdata_i,
	input wire logic               wr_i,
	input wire logic               rd_i,
	input wire logic [15:0]        rdata_o,
	// pins and outputs
	input wire gtu_pkg::gtu_pins_t pins_i,
	input wire logic               core_toggle_o,
	input wire logic               fast_toggle_o,
	input wire logic               cmp_tick_o
);
	// ==========================================
	// mirrors of the two output enables
	logic core_en_q; // core control bit 15
	logic fast_en_q; // second core control bit 8

	// follow software writes to the enables
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			core_en_q <= 1'b0;
			fast_en_q <= 1'b0;
		end else if (wr_i && addr_i == 4'h0) begin
			core_en_q <= wdata_i[15];
		end else if (wr_i && addr_i == 4'h4) begin
			fast_en_q <= wdata_i[8];
		end
	end

	// ==========================================
	// properties
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	// read of an unmapped word
	sequence s_rd_resv;
		rd_i && addr_i >= 4'hc;
	endsequence
	// wrap seen while the output stayed enabled
	sequence s_wrap_on;
		cmp_tick_o && $past(fast_en_q) && $past(fast_en_q, 2);
	endsequence

	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data not zero outside a read");
	a_resv_zero: assert property (s_rd_resv |=> rdata_o == 16'h0000)
		else $error("unmapped word read not zero");
	a_reset_quiet: assert property ($past(srst_i) |->
		!core_toggle_o && !fast_toggle_o && !cmp_tick_o)
		else $error("outputs active after reset");
	a_tick_pulse: assert property (cmp_tick_o |=> !cmp_tick_o)
		else $error("compare tick longer than one cycle");
	a_fast_follow: assert property (s_wrap_on |-> $changed(fast_toggle_o))
		else $error("fast toggle did not follow wrap");
	a_fast_cause: assert property ($changed(fast_toggle_o) &&
		$past(fast_en_q) && $past(fast_en_q, 2) |-> cmp_tick_o)
		else $error("fast toggle moved without wrap");
	a_fast_off: assert property (!fast_en_q && !$past(fast_en_q)
		|-> !fast_toggle_o)
		else $error("fast toggle driven while disabled");
	a_core_off: assert property (!core_en_q && !$past(core_en_q)
		|-> !core_toggle_o)
		else $error("core toggle driven while disabled");

	c_wrap: cover property (s_wrap_on);
endmodule

bind gtu_general_timer_unit gtu_chk u_chk (
	.mclk_i        (mclk_i),
	.srst_i        (srst_i),
	.addr_i        (addr_i),
	.wdata_i       (wdata_i),
	.wr_i          (wr_i),
	.rd_i          (rd_i),
	.rdata_o       (rdata_o),
	.pins_i        (pins_i),
	.core_toggle_o (core_toggle_o),
	.fast_toggle_o (fast_toggle_o),
	.cmp_tick_o    (cmp_tick_o)
);

// file: verif/gtu_pin_model.sv
// pin model: sensors and switches on the unit's external pins
`timescale 1ns/1ps

module gtu_pin_model (
	// clock
	input  wire logic          mclk_i,
	// pins toward the unit
	output gtu_pkg::gtu_pins_t pins_o
);
	logic [10:0] pins_q; // levels, struct order, core_in on top
	int          phase;  // encoder phase 0..3

	assign pins_o = pins_q;

	// all pins low, encoder at rest
	initial begin
		pins_q = '0;
		phase = 0;
	end

	// hold a level, changed just after an edge
	task automatic set_pin(input int i, input logic b);
		@(posedge mclk_i);
		pins_q[i] <= b;
	endtask

	// pulse wide enough for the synchroniser
	task automatic pulse(input int i);
		repeat (4) @(posedge mclk_i);
		pins_q[i] <= 1'b1;
		repeat (4) @(posedge mclk_i);
		pins_q[i] <= 1'b0;
		repeat (4) @(posedge mclk_i);
	endtask

	// quadrature steps, A on core_in, B on core_dir
	task automatic enc(input int n, input bit fwd);
		repeat (n) begin
			phase = fwd ? (phase + 1) % 4 : (phase + 3) % 4;
			@(posedge mclk_i);
			pins_q[10] <= phase[0] ^ phase[1];
			pins_q[9]  <= phase[1];
			repeat (4) @(posedge mclk_i);
		end
	endtask
endmodule

// file: verif/testbench.sv
// testbench: registers, timers, pins and toggles of the timer unit
`timescale 1ns/1ps

module testbench;
	// ==========================================
	// design signals and bench state
	logic               mclk_i;
	logic               srst_i;
	logic [3:0]         addr_i;
	logic [15:0]        wdata_i;
	logic               wr_i;
	logic               rd_i;
	logic [15:0]        rdata_o;
	gtu_pkg::gtu_pins_t pins_i;
	logic               core_toggle_o;
	logic               fast_toggle_o;
	logic               cmp_tick_o;
	int                 mismatches;
	int                 n_tests;
	int                 seed;
	int                 n;
	int                 s;
	logic [15:0]        v;
	logic [15:0]        x;

	gtu_general_timer_unit uut (
		.mclk_i        (mclk_i),
		.srst_i        (srst_i),
		.addr_i        (addr_i),
		.wdata_i       (wdata_i),
		.wr_i          (wr_i),
		.rd_i          (rd_i),
		.rdata_o       (rdata_o),
		.pins_i        (pins_i),
		.core_toggle_o (core_toggle_o),
		.fast_toggle_o (fast_toggle_o),
		.cmp_tick_o    (cmp_tick_o)
	);

	gtu_pin_model pm (
		.mclk_i (mclk_i),
		.pins_o (pins_i)
	);

	// 40 MHz system clock
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	// counts and verdict, then stop
	task automatic test_done();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// value compare, modular tolerance t
	task automatic chk(input logic [15:0] g, input logic [15:0] e,
			input int t);
		logic [15:0] d;
		d = g - e;
		n_tests++;
		if ($isunknown(g) || !(d <= t || 16'(-d) <= t)) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask

	// steps after c clocks at base b, prescale p
	function automatic logic [15:0] steps(input int c, input int b,
			input int p);
		return 16'(c / (b << p));
	endfunction

	// one-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i    <= 1'b0;
		@(posedge mclk_i);
	endtask

	// read, data taken in the following cycle, then compared
	task automatic rchk(input logic [3:0] a, input logic [15:0] e,
			input int t);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge mclk_i);
		rd_i   <= 1'b0;
		#1 v = rdata_o;
		chk(v, e, t);
		@(posedge mclk_i);
	endtask

	// bounded wait for a compare tick, c = cycles waited
	task automatic wait_tick(output int c);
		for (c = 1; c <= 300; c++) begin
			@(posedge mclk_i);
			#1;
			if (cmp_tick_o === 1'b1) return;
		end
		mismatches++;
		$display("mismatch at %0t: no compare tick", $time);
		test_done();
	endtask

	// reset held two cycles
	task automatic do_reset();
		srst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		srst_i <= 1'b0;
		@(posedge mclk_i);
	endtask

	// ==========================================
	// main sequence
	initial begin
		seed = 23;
		mismatches = 0;
		n_tests = 0;
		addr_i = 4'h0;
		wdata_i = 16'h0000;
		wr_i = 1'b0;
		rd_i = 1'b0;
		srst_i = 1'b1;
		repeat (2) @(posedge mclk_i);
		srst_i <= 1'b0;
		@(posedge mclk_i);
		// cleared words, status and unmapped words read zero
		for (int a = 0; a < 16; a++) rchk(4'(a), 16'h0000, 0);
		// group-one controls hold random words
		for (int i = 0; i < 3; i++) begin
			x = 16'($random(seed));
			wr(4'(i), x);
			rchk(4'(i), x, 0);
		end
		wr(4'hc, 16'($random(seed)));
		rchk(4'hc, 16'h0000, 0);
		do_reset();
		// prescaled counting, both groups, up and down
		for (int i = 0; i < 4; i++) begin
			s = (i < 2) ? 0 : 4;
			x = (s == 0) ? 16'(4 | (i % 2) << 3 | i << 5)
				: 16'(2 | (i % 2) << 2 | i << 4);
			wr(4'(5 + s), 16'h0000);
			wr(4'(s), x);
			repeat (160) @(posedge mclk_i);
			v = steps(162, (s == 0) ? 4 : 2, i);
			rchk(4'(5 + s), (i % 2) ? 16'(-v) : v, 1);
			wr(4'(s), 16'h0000);
		end
		do_reset();
		// second core wraps, reloads and toggles
		wr(4'ha, 16'hfff8);
		wr(4'h9, 16'hfff0);
		wr(4'h4, 16'h0302);
		wait_tick(n);
		chk(16'(fast_toggle_o), 16'h0001, 0);
		for (int i = 0; i < 2; i++) begin
			wait_tick(n);
			chk(16'(n), 16'h0010, 0);
			chk(16'(fast_toggle_o), 16'(i % 2), 0);
		end
		wr(4'h4, 16'h0000);
		// core underflow sets the toggle output
		wr(4'h5, 16'h0002);
		wr(4'h0, 16'h800c);
		repeat (20) @(posedge mclk_i);
		#1 chk(16'(core_toggle_o), 16'h0001, 0);
		wr(4'h0, 16'h0000);
		// pin counting, direction pin reverses it
		wr(4'h5, 16'h0000);
		wr(4'h0, 16'h0816);
		repeat (5) pm.pulse(10);
		rchk(4'h5, 16'h0005, 0);
		pm.set_pin(9, 1'b1);
		repeat (3) pm.pulse(10);
		rchk(4'h5, 16'h0002, 0);
		pm.set_pin(9, 1'b0);
		// encoder: five steps on, two back
		wr(4'h5, 16'h0000);
		wr(4'h0, 16'h0007);
		pm.enc(5, 1'b1);
		pm.enc(2, 1'b0);
		rchk(4'h5, 16'h0003, 0);
		wr(4'h0, 16'h0000);
		// gated counting on the low aux timer
		wr(4'h6, 16'h0000);
		wr(4'h1, 16'h8005);
		pm.set_pin(8, 1'b1);
		repeat (80) @(posedge mclk_i);
		pm.set_pin(8, 1'b0);
		repeat (40) @(posedge mclk_i);
		rchk(4'h6, steps(81, 4, 0), 1);
		// core latch reloads the core and clocks the low aux timer
		wr(4'h7, 16'h0003);
		wr(4'h2, 16'h6400);
		wr(4'h6, 16'h0000);
		wr(4'h1, 16'h1906);
		wr(4'h5, 16'h0000);
		wr(4'h0, 16'h000c);
		repeat (160) @(posedge mclk_i);
		rchk(4'h6, steps(160, 16, 0), 1);
		wr(4'h0, 16'h0000);
		wr(4'h2, 16'h0000);
		// capture of the stopped core, aux left running
		x = 16'($random(seed));
		wr(4'h5, x);
		wr(4'h1, 16'h0a04);
		pm.pulse(8);
		rchk(4'h6, x, 0);
		wr(4'h1, 16'h0000);
		// pin reload of the core from the high aux timer
		x = 16'($random(seed));
		wr(4'h7, x);
		wr(4'h2, 16'h0c00);
		pm.pulse(6);
		rchk(4'h5, x, 0);
		wr(4'h2, 16'h0000);
		// capture of the second aux with clear, then from core_in
		x = 16'($random(seed));
		wr(4'h8, x);
		wr(4'h3, 16'h1400);
		pm.pulse(0);
		rchk(4'ha, x, 0);
		rchk(4'h8, 16'h0000, 0);
		x = 16'($random(seed));
		wr(4'h8, x);
		wr(4'h3, 16'h3400);
		pm.pulse(10);
		rchk(4'ha, x, 0);
		// second aux on its own pin, then reversed by its direction pin
		wr(4'h8, 16'h0000);
		wr(4'h3, 16'h000b);
		repeat (3) pm.pulse(4);
		rchk(4'h8, 16'h0003, 0);
		pm.set_pin(3, 1'b1);
		pm.pulse(4);
		rchk(4'h8, 16'h0002, 0);
		pm.set_pin(3, 1'b0);
		test_done();
	end
endmodule
